// File: common/prtr_pkg.sv
package prtr_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] PRTR_ADDR_P_LO   = 8'h28;
  localparam logic [7:0] PRTR_ADDR_P_MID  = 8'h29;
  localparam logic [7:0] PRTR_ADDR_P_HI   = 8'h2a;
  localparam logic [7:0] PRTR_ADDR_T_LO   = 8'h2b;
  localparam logic [7:0] PRTR_ADDR_T_HI   = 8'h2c;
  localparam logic [7:0] PRTR_ADDR_AMP    = 8'h2d;
  localparam logic [7:0] PRTR_ADDR_CAL_LO = 8'h3c;
  localparam logic [7:0] PRTR_ADDR_CAL_MI = 8'h3d;
  localparam logic [7:0] PRTR_ADDR_CAL_HI = 8'h3e;

  // values after reset
  localparam logic [7:0] PRTR_RST_P_LO  = 8'h00;
  localparam logic [7:0] PRTR_RST_P_MID = 8'h80;
  localparam logic [7:0] PRTR_RST_P_HI  = 8'h2f;
  localparam logic [7:0] PRTR_RST_T     = 8'h00;
  localparam logic [7:0] PRTR_RST_AMP   = 8'h00;
  localparam logic [7:0] PRTR_RST_CAL   = 8'h00;
  localparam logic [7:0] PRTR_RD_NONE   = 8'h00;

  // field positions
  localparam int PRTR_AMP_SEL_BIT  = 0;
  localparam int PRTR_DELTA_EN_BIT = 1;

  // scaling: mbar = value / 4096, degc = 42.5 + value / 480
  localparam int PRTR_P_LSB_PER_MBAR  = 4096;
  localparam int PRTR_T_LSB_PER_DEGC  = 480;
  localparam int PRTR_T_ZERO_DECIDEGC = 425;

  // operating range 260..1260 mbar in output counts
  localparam logic [24:0] PRTR_P_MIN = 25'h0104000;
  localparam logic [24:0] PRTR_P_MAX = 25'h04ec000;

  typedef enum logic [1:0] {
    PRTR_ACQ_IDLE,
    PRTR_ACQ_PRESS,
    PRTR_ACQ_TEMP
  } prtr_acq_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prtr_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] value;
  } prtr_press_smp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } prtr_temp_smp_t;

  // byte idx of a 24-bit word
  function automatic logic [7:0] prtr_byte(input logic [23:0] w,
                                           input logic [1:0]  idx);
    prtr_byte = w[8*idx +: 8];
  endfunction : prtr_byte

endpackage : prtr_pkg

// File: verilog/prtr_press_corr.sv
`timescale 1ns/1ps
`default_nettype none
module prtr_press_corr
  import prtr_pkg::*;
(
  input  wire logic [23:0] raw_value,
  input  wire logic [23:0] calibration_offset,
  input  wire logic        offset_enable,
  output logic      [23:0] corr_value
);

  logic [24:0] raw_ext;
  logic [24:0] cal_ext;
  logic [24:0] sum;
  logic        below;
  logic        above;

  // optional one-point offset, then saturate to the operating range
  assign raw_ext = {raw_value[23], raw_value};
  assign cal_ext = offset_enable ? {calibration_offset[23], calibration_offset}
                                 : 25'h0000000;
  assign sum     = raw_ext + cal_ext;
  assign below   = $signed(sum) < $signed(PRTR_P_MIN);
  assign above   = $signed(sum) > $signed(PRTR_P_MAX);
  assign corr_value = below ? PRTR_P_MIN[23:0] :
                      above ? PRTR_P_MAX[23:0] : sum[23:0];

endmodule : prtr_press_corr
`default_nettype wire

// File: verilog/prtr_amp_sel.sv
`timescale 1ns/1ps
`default_nettype none
module prtr_amp_sel
  import prtr_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      reset_n,
  input  wire logic      amp_current_select,
  input  wire prtr_acq_t acq_phase,
  output logic           amp_high_current
);

  logic phase_high;
  logic amp_next;

  // high current while pressure is acquired
  assign phase_high = (acq_phase == PRTR_ACQ_PRESS);
  assign amp_next   = amp_current_select | phase_high;

  // registered bias request
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      amp_high_current <= 1'b0;
    end else begin
      amp_high_current <= amp_next;
    end
  end

endmodule : prtr_amp_sel
`default_nettype wire

// File: verilog/prtr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module prtr_regs
  import prtr_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire prtr_reg_req_t   reg_req,
  output logic [7:0]           reg_rd_data,
  output logic                 reg_rd_valid,
  input  wire logic [7:0]      first_control_register,
  input  wire prtr_press_smp_t press_smp,
  input  wire prtr_temp_smp_t  temp_smp,
  input  wire prtr_acq_t       acq_phase,
  output logic                 amp_high_current,
  output logic                 pressure_available_flag,
  output logic                 pressure_overrun_flag,
  output logic                 temp_available_flag,
  output logic                 temp_overrun_flag
);

  // result and calibration storage
  logic [23:0] press_reg;
  logic [23:0] press_next;
  logic [15:0] temperature_result_bits_reg;
  logic [7:0]  amplifier_current_control_reg;
  logic [23:0] calibration_offset_reg;
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;
  logic        rd_valid_reg;

  // status flags
  logic p_avail_reg;
  logic p_avail_next;
  logic p_ovr_reg;
  logic p_ovr_next;
  logic t_avail_reg;
  logic t_avail_next;
  logic t_ovr_reg;
  logic t_ovr_next;

  // address decode
  logic hit_p_lo;
  logic hit_p_mid;
  logic hit_p_hi;
  logic hit_t_lo;
  logic hit_t_hi;
  logic hit_amp;
  logic hit_cal_lo;
  logic hit_cal_mi;
  logic hit_cal_hi;
  logic wr_amp;
  logic wr_cal_lo;
  logic wr_cal_mi;
  logic wr_cal_hi;
  logic rd_p_hi;
  logic rd_t_hi;

  // control derived from registers
  logic amp_current_select;
  logic offset_enable;
  logic [23:0] corr_value;

  // decode of the register address
  assign hit_p_lo   = (reg_req.addr == PRTR_ADDR_P_LO);
  assign hit_p_mid  = (reg_req.addr == PRTR_ADDR_P_MID);
  assign hit_p_hi   = (reg_req.addr == PRTR_ADDR_P_HI);
  assign hit_t_lo   = (reg_req.addr == PRTR_ADDR_T_LO);
  assign hit_t_hi   = (reg_req.addr == PRTR_ADDR_T_HI);
  assign hit_amp    = (reg_req.addr == PRTR_ADDR_AMP);
  assign hit_cal_lo = (reg_req.addr == PRTR_ADDR_CAL_LO);
  assign hit_cal_mi = (reg_req.addr == PRTR_ADDR_CAL_MI);
  assign hit_cal_hi = (reg_req.addr == PRTR_ADDR_CAL_HI);

  // writes reach only the read/write registers
  assign wr_amp    = reg_req.wr_en & hit_amp;
  assign wr_cal_lo = reg_req.wr_en & hit_cal_lo;
  assign wr_cal_mi = reg_req.wr_en & hit_cal_mi;
  assign wr_cal_hi = reg_req.wr_en & hit_cal_hi;

  // reads of the high bytes retire the matching flags
  assign rd_p_hi = reg_req.rd_en & hit_p_hi;
  assign rd_t_hi = reg_req.rd_en & hit_t_hi;

  // control bits
  assign amp_current_select = amplifier_current_control_reg[PRTR_AMP_SEL_BIT];
  assign offset_enable      = first_control_register[PRTR_DELTA_EN_BIT];

  // offset and clip on the incoming sample
  prtr_press_corr u_corr (
    .raw_value          (press_smp.value),
    .calibration_offset (calibration_offset_reg),
    .offset_enable      (offset_enable),
    .corr_value         (corr_value)
  );

  // amplifier bias follows the selector and phase
  prtr_amp_sel u_amp (
    .core_clk           (core_clk),
    .reset_n            (reset_n),
    .amp_current_select (amp_current_select),
    .acq_phase          (acq_phase),
    .amp_high_current   (amp_high_current)
  );

  // new pressure replaces the whole 24-bit result at once
  assign press_next = press_smp.valid ? corr_value : press_reg;

  // pressure result, written only by the converter side
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      press_reg <= {PRTR_RST_P_HI, PRTR_RST_P_MID, PRTR_RST_P_LO};
    end else begin
      press_reg <= press_next;
    end
  end

  // temperature result, written only by the converter side
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      temperature_result_bits_reg <= {PRTR_RST_T, PRTR_RST_T};
    end else if (temp_smp.valid) begin
      temperature_result_bits_reg <= temp_smp.value;
    end
  end

  // amplifier control, reserved bits held at zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      amplifier_current_control_reg <= PRTR_RST_AMP;
    end else if (wr_amp) begin
      amplifier_current_control_reg <= {7'h00, reg_req.wdata[PRTR_AMP_SEL_BIT]};
    end
  end

  // calibration offset bytes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      calibration_offset_reg <= {PRTR_RST_CAL, PRTR_RST_CAL, PRTR_RST_CAL};
    end else begin
      if (wr_cal_lo) begin
        calibration_offset_reg[7:0] <= reg_req.wdata;
      end
      if (wr_cal_mi) begin
        calibration_offset_reg[15:8] <= reg_req.wdata;
      end
      if (wr_cal_hi) begin
        calibration_offset_reg[23:16] <= reg_req.wdata;
      end
    end
  end

  // status flag next values: a new sample wins over a clearing read for the available flags, the read wins for overrun
  assign p_avail_next = press_smp.valid | (p_avail_reg & ~rd_p_hi);
  assign p_ovr_next   = (press_smp.valid & p_avail_reg & ~rd_p_hi)
                      | (p_ovr_reg & ~rd_p_hi);
  assign t_avail_next = temp_smp.valid | (t_avail_reg & ~rd_t_hi);
  assign t_ovr_next   = (temp_smp.valid & t_avail_reg & ~rd_t_hi)
                      | (t_ovr_reg & ~rd_t_hi);

  // status flags
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      p_avail_reg <= 1'b0;
      p_ovr_reg   <= 1'b0;
      t_avail_reg <= 1'b0;
      t_ovr_reg   <= 1'b0;
    end else begin
      p_avail_reg <= p_avail_next;
      p_ovr_reg   <= p_ovr_next;
      t_avail_reg <= t_avail_next;
      t_ovr_reg   <= t_ovr_next;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_data_next = PRTR_RD_NONE;
    case (1'b1)
      hit_p_lo:   rd_data_next = prtr_byte(press_reg, 2'd0);
      hit_p_mid:  rd_data_next = prtr_byte(press_reg, 2'd1);
      hit_p_hi:   rd_data_next = prtr_byte(press_reg, 2'd2);
      hit_t_lo:   rd_data_next = temperature_result_bits_reg[7:0];
      hit_t_hi:   rd_data_next = temperature_result_bits_reg[15:8];
      hit_amp:    rd_data_next = amplifier_current_control_reg;
      hit_cal_lo: rd_data_next = prtr_byte(calibration_offset_reg, 2'd0);
      hit_cal_mi: rd_data_next = prtr_byte(calibration_offset_reg, 2'd1);
      hit_cal_hi: rd_data_next = prtr_byte(calibration_offset_reg, 2'd2);
      default:    rd_data_next = PRTR_RD_NONE;
    endcase
  end

  // read data is captured one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_data_reg  <= PRTR_RD_NONE;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_req.rd_en;
      if (reg_req.rd_en) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  // outputs
  assign reg_rd_data             = rd_data_reg;
  assign reg_rd_valid            = rd_valid_reg;
  assign pressure_available_flag = p_avail_reg;
  assign pressure_overrun_flag   = p_ovr_reg;
  assign temp_available_flag     = t_avail_reg;
  assign temp_overrun_flag       = t_ovr_reg;

endmodule : prtr_regs
`default_nettype wire

// File: verif/prtr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module prtr_regs_sva
  import prtr_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            reset_n,
  input wire prtr_reg_req_t   reg_req,
  input wire logic [7:0]      reg_rd_data,
  input wire logic            reg_rd_valid,
  input wire logic [7:0]      first_control_register,
  input wire prtr_press_smp_t press_smp,
  input wire prtr_temp_smp_t  temp_smp,
  input wire prtr_acq_t       acq_phase,
  input wire logic            amp_high_current,
  input wire logic            pressure_available_flag,
  input wire logic            pressure_overrun_flag,
  input wire logic            temp_available_flag,
  input wire logic            temp_overrun_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // decoded high-byte pressure read
  wire logic p_hi_rd = reg_req.rd_en && (reg_req.addr == PRTR_ADDR_P_HI);

  // register port answers and holds
  rd_valid_a: assert property (reg_req.rd_en |=> reg_rd_valid)
    else $error("read not answered");
  rd_hold_a: assert property (!reg_req.rd_en |=> !reg_rd_valid && $stable(reg_rd_data))
    else $error("read data moved without read");
  unmapped_rd_a: assert property (reg_req.rd_en && reg_req.addr == 8'h00 |=> reg_rd_data == PRTR_RD_NONE)
    else $error("unmapped read not zero");
  p_range_a: assert property (p_hi_rd |=> reg_rd_data inside {[PRTR_P_MIN[23:16]:PRTR_P_MAX[23:16]]})
    else $error("pressure high byte out of range");
  // amplifier and flags
  amp_press_a: assert property (acq_phase == PRTR_ACQ_PRESS |=> amp_high_current)
    else $error("amplifier low during pressure");
  p_flag_a: assert property (press_smp.valid |=> pressure_available_flag)
    else $error("pressure flag not set");
  t_flag_a: assert property (temp_smp.valid |=> temp_available_flag)
    else $error("temperature flag not set");
  p_clear_a: assert property (p_hi_rd && !press_smp.valid |=> !pressure_available_flag)
    else $error("pressure flag not cleared");
  p_ovr_a: assert property (press_smp.valid && pressure_available_flag && !p_hi_rd
                            |=> pressure_overrun_flag)
    else $error("pressure overrun missed");

  // main scenarios
  cover property (press_smp.valid && first_control_register[1]);
  cover property (reg_req.wr_en && reg_req.addr == PRTR_ADDR_CAL_HI);
  cover property (pressure_overrun_flag);
  cover property (temp_overrun_flag);
endmodule : prtr_regs_sva

bind prtr_regs prtr_regs_sva prtr_regs_sva_i (.core_clk(core_clk), .reset_n(reset_n),
  .reg_req(reg_req), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .first_control_register(first_control_register), .press_smp(press_smp),
  .temp_smp(temp_smp), .acq_phase(acq_phase), .amp_high_current(amp_high_current),
  .pressure_available_flag(pressure_available_flag),
  .pressure_overrun_flag(pressure_overrun_flag),
  .temp_available_flag(temp_available_flag), .temp_overrun_flag(temp_overrun_flag));
`default_nettype wire

// File: verif/prtr_host.sv
`timescale 1ns/1ps
`default_nettype none
module prtr_host
  import prtr_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic [7:0]    reg_rd_data,
  input  wire logic          reg_rd_valid,
  output var prtr_reg_req_t  reg_req
);
  // idle request at time zero
  initial reg_req = '0;

  // one-cycle write strobe, then lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // one-cycle read strobe, answer taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    reg_req = '{1'b0, 1'b0, ~a, 8'hff};
    d = reg_rd_data;
    v = reg_rd_valid;
  endtask : rd
endmodule : prtr_host
`default_nettype wire

// File: verif/tb_prtr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_prtr_regs
  import prtr_pkg::*;
;
  logic            core_clk, reset_n, rd_valid, amp, pflag, povr, tflag, tovr;
  logic [7:0]      rd_data, ctrl;
  prtr_reg_req_t   req;
  prtr_press_smp_t psmp;
  prtr_temp_smp_t  tsmp;
  prtr_acq_t       acq;
  int              fails, checked, cyc;

  prtr_regs prtr_regs_i (.core_clk(core_clk), .reset_n(reset_n), .reg_req(req),
    .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .first_control_register(ctrl),
    .press_smp(psmp), .temp_smp(tsmp), .acq_phase(acq), .amp_high_current(amp),
    .pressure_available_flag(pflag), .pressure_overrun_flag(povr),
    .temp_available_flag(tflag), .temp_overrun_flag(tovr));
  prtr_host prtr_host_i (.core_clk(core_clk), .reg_rd_data(rd_data),
    .reg_rd_valid(rd_valid), .reg_req(req));

  // clock and cycle ceiling
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", n, exp, seen);
      fails++;
    end
  endtask : chk

  task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    prtr_host_i.rd(a, d, v);
    chk("read", {v, d}, {1'b1, exp});
  endtask : rd8

  task automatic rd24(input logic [7:0] a, input logic [23:0] exp);
    rd8(a, exp[7:0]);
    rd8(a + 8'h01, exp[15:8]);
    rd8(a + 8'h02, exp[23:16]);
  endtask : rd24

  task automatic ps(input logic [23:0] v);
    @(negedge core_clk);
    psmp = '{1'b1, v};
    @(negedge core_clk);
    psmp = '{1'b0, ~v};
  endtask : ps

  // main sequence
  initial begin
    reset_n = 1'b0;
    ctrl = 8'h00;
    psmp = '0;
    tsmp = '0;
    acq = PRTR_ACQ_IDLE;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    rd24(PRTR_ADDR_P_LO, 24'h2f8000);
    rd8(PRTR_ADDR_T_LO, 8'h00);
    rd8(PRTR_ADDR_T_HI, 8'h00);
    rd8(PRTR_ADDR_AMP, 8'h00);
    rd24(PRTR_ADDR_CAL_LO, 24'h000000);
    rd8(8'h00, 8'h00);
    prtr_host_i.wr(PRTR_ADDR_P_LO, 8'h55);
    prtr_host_i.wr(PRTR_ADDR_T_HI, 8'h55);
    rd8(PRTR_ADDR_P_LO, 8'h00);
    rd8(PRTR_ADDR_T_HI, 8'h00);
    prtr_host_i.wr(PRTR_ADDR_CAL_LO, 8'h00);
    prtr_host_i.wr(PRTR_ADDR_CAL_MI, 8'h10);
    prtr_host_i.wr(PRTR_ADDR_CAL_HI, 8'h01);
    rd24(PRTR_ADDR_CAL_LO, 24'h011000);
    // amplifier current selection
    prtr_host_i.wr(PRTR_ADDR_AMP, 8'hff);
    rd8(PRTR_ADDR_AMP, 8'h01);
    acq = PRTR_ACQ_TEMP;
    repeat (2) @(negedge core_clk);
    chk("amp", amp, 1);
    prtr_host_i.wr(PRTR_ADDR_AMP, 8'h00);
    repeat (2) @(negedge core_clk);
    chk("amp", amp, 0);
    acq = PRTR_ACQ_PRESS;
    repeat (2) @(negedge core_clk);
    chk("amp", amp, 1);
    acq = PRTR_ACQ_IDLE;
    // pressure samples, offset and clipping
    ps(24'h3f8000);
    chk("pflag", pflag, 1);
    rd24(PRTR_ADDR_P_LO, 24'h3f8000);
    chk("pflag", pflag, 0);
    ctrl = 8'h02;
    ps(24'h3f8000);
    rd24(PRTR_ADDR_P_LO, 24'h409000);
    ctrl = 8'hfd;
    ps(24'h3f8000);
    rd24(PRTR_ADDR_P_LO, 24'h3f8000);
    ps(24'h7fffff);
    ps(24'hff0000);
    chk("povr", povr, 1);
    rd24(PRTR_ADDR_P_LO, 24'h104000);
    ps(24'h7fffff);
    rd24(PRTR_ADDR_P_LO, 24'h4ec000);
    // temperature sample
    @(negedge core_clk);
    tsmp = '{1'b1, 16'hfe20};
    @(negedge core_clk);
    tsmp = '{1'b0, 16'h01df};
    chk("tflag", tflag, 1);
    rd8(PRTR_ADDR_T_LO, 8'h20);
    rd8(PRTR_ADDR_T_HI, 8'hfe);
    chk("tflag", tflag, 24'h000000);
    // two temperature samples without a read set the overrun flag
    @(negedge core_clk);
    tsmp = '{1'b1, 16'h0140};
    @(negedge core_clk);
    tsmp = '{1'b1, 16'h0260};
    @(negedge core_clk);
    tsmp = '{1'b0, 16'hfd9f};
    chk("tovr", tovr, 24'h000001);
    rd8(PRTR_ADDR_T_HI, 8'h02);
    chk("tovr", tovr, 24'h000000);
    test_done();
  end
endmodule : tb_prtr_regs
`default_nettype wire
